// ==== nvs_cfg.svh ====
// Constants of the flash command sequencer: command codes, timing, map.
// Assumes inclusion by bare name from the design modules; the package does not include it.
`ifndef NVS_CFG_SVH
`define NVS_CFG_SVH
// Command codes
`define NVS_CMD_NOP       7'h00
`define NVS_CMD_USR_RD    7'h01
`define NVS_CMD_FAC_RD    7'h02
`define NVS_CMD_USR_ER    7'h18
`define NVS_CMD_USR_WR    7'h1a
`define NVS_CMD_MAIN_ER   7'h20
`define NVS_CMD_MPG_ER    7'h22
`define NVS_CMD_BUF_LD    7'h23
`define NVS_CMD_MPG_WR    7'h24
`define NVS_CMD_MPG_EW    7'h25
`define NVS_CMD_BUF_ER    7'h26
`define NVS_CMD_BPG_ER    7'h2a
`define NVS_CMD_PG_ER     7'h2b
`define NVS_CMD_BPG_WR    7'h2c
`define NVS_CMD_BPG_EW    7'h2d
`define NVS_CMD_PG_WR     7'h2e
`define NVS_CMD_PG_EW     7'h2f
`define NVS_CMD_EE_LD     7'h33
`define NVS_CMD_EE_ER     7'h30
`define NVS_CMD_EE_RD     7'h06
`define NVS_CMD_MAIN_CRC  7'h38
`define NVS_CMD_BOOT_CRC  7'h39
`define NVS_CMD_RNG_CRC   7'h3a
// Timing in clock cycles
`define NVS_OP_CYCLES     8'h10
`define NVS_CCP_CYCLES    3'h4
// Checksum engine
`define NVS_CRC_INIT      16'hffff
`define NVS_CRC_POLY      16'h1021
// Linear map of the external programming space
`define NVS_MAP_EE        24'h001000
`define NVS_MAP_USR       24'h002000
`define NVS_MAP_FAC       24'h003000
`define NVS_ERASED        8'hff
`endif

// ==== nvs_crc.sv ====
// One-byte update of a 16-bit checksum, combinational.
// Assumes the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "nvs_cfg.svh"
module nvs_crc (
    input  wire logic [15:0] crcIn,
    input  wire logic [7:0]  byteIn,
    output logic      [15:0] crcOut
);
    // ==========================================================
    // Bitwise shift through the polynomial
    always_comb begin
        logic [15:0] c;
        c = crcIn ^ {byteIn, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ((c << 1) ^ `NVS_CRC_POLY) : (c << 1);
        end
        crcOut = c;
    end
endmodule : nvs_crc
`default_nettype wire

// ==== nvs_device.sv ====
// Memory controller end: command decode, flash, rows, EEPROM, checksum.
// Assumes the CPU end on nvs_if.dev, same clock, lock state from fuses.
`timescale 1ns/1ps
`default_nettype none
`include "nvs_cfg.svh"
module nvs_device import nvs_pkg::*; #(
    parameter int FLASH_BYTES = 64,
    parameter int PAGE_BYTES  = 8,
    parameter int BOOT_BYTES  = 16,
    parameter int EE_BYTES    = 16,
    parameter int EE_PAGE     = 4
) (
    input  wire logic        clk,
    input  wire logic        srst,
    nvs_if.dev               lnk,
    input  wire logic        bootLockFree,
    input  wire logic        extReq,
    input  wire logic [23:0] extAddr,
    output logic             extValid,
    output logic [7:0]       extData
);
    localparam int FA = $clog2(FLASH_BYTES);
    localparam int EA = $clog2(EE_BYTES);
    localparam int PA = $clog2(PAGE_BYTES);
    localparam int EP = $clog2(EE_PAGE);
    localparam int NEP = EE_BYTES / EE_PAGE;
    localparam logic [FA-1:0] BOOT_START = FA'(FLASH_BYTES - BOOT_BYTES);
    typedef struct packed {
        logic [FLASH_BYTES-1:0][7:0] flash;
        logic [PAGE_BYTES-1:0][7:0]  pbuf;
        logic [PAGE_BYTES-1:0][7:0]  urow;
        logic [EE_BYTES-1:0][7:0]    ee;
        logic [NEP-1:0]              eeTag;
        logic [6:0]                  cmd;
        logic [23:0]                 addr;
        logic [23:0]                 data;
        logic [2:0]                  ccpCnt;
        nvs_dstate_t                 st;
        logic [6:0]                  opCmd;
        logic [FA-1:0]               opAddr;
        logic [FA-1:0]               crcEnd;
        logic [7:0]                  cnt;
        logic [15:0]                 crc;
        logic                        busy;
        logic                        halt;
        logic                        lpmValid;
        logic [7:0]                  lpmData;
        logic                        extValid;
        logic [7:0]                  extData;
    } nvs_dev_t;
    nvs_dev_t    s_q;
    nvs_dev_t    s_d;
    logic [15:0] crcNext;
    // ==========================================================
    // Helpers
    function automatic logic [FA-PA-1:0] pageOf(input logic [FA-1:0] a);
        pageOf = a[FA-1:PA];
    endfunction : pageOf
    function automatic logic [7:0] facByte(input logic [PA-1:0] i);
        facByte = {4'h5, 4'(i)};  // Fixed production values, arbitrary
    endfunction : facByte
    function automatic logic [7:0] mapRead(input nvs_dev_t s,
                                           input logic [23:0] a);
        mapRead = `NVS_ERASED;
        if (a < 24'(FLASH_BYTES))
            mapRead = s.flash[a[FA-1:0]];
        else if (a >= `NVS_MAP_EE && a < `NVS_MAP_EE + 24'(EE_BYTES))
            mapRead = s.ee[a[EA-1:0]];
        else if (a >= `NVS_MAP_USR && a < `NVS_MAP_USR + 24'(PAGE_BYTES))
            mapRead = s.urow[a[PA-1:0]];
        else if (a >= `NVS_MAP_FAC && a < `NVS_MAP_FAC + 24'(PAGE_BYTES))
            mapRead = facByte(a[PA-1:0]);
    endfunction : mapRead
    // ==========================================================
    // Checksum engine
    nvs_crc nvs_crc_i (
        .crcIn  (s_q.crc),
        .byteIn (s_q.flash[s_q.opAddr]),
        .crcOut (crcNext)
    );

    // ==========================================================
    // Next state
    always_comb begin
        logic          prot, spmOk, exOk;
        logic [6:0]    c;
        logic [FA-1:0] za;
        s_d = s_q;
        c = s_q.cmd;
        za = lnk.ptrAddr[FA-1:0];
        prot = (s_q.ccpCnt != 3'h0);
        spmOk = lnk.spmReq && !s_q.busy;
        exOk = lnk.execReq && !s_q.busy && prot;
        s_d.lpmValid = lnk.lpmReq;
        s_d.extValid = extReq;
        // Register writes and unlock window
        if (lnk.cmdWr) s_d.cmd = lnk.cmdVal;
        if (lnk.addrWr) s_d.addr = lnk.addrVal;
        if (lnk.dataWr) s_d.data = lnk.dataVal;
        if (lnk.ccpKey) s_d.ccpCnt = `NVS_CCP_CYCLES;
        else if (prot) s_d.ccpCnt = s_q.ccpCnt - 3'h1;
        if (extReq) s_d.extData = mapRead(s_q, extAddr);
        if (lnk.lpmReq)
            case (c)
                `NVS_CMD_USR_RD: s_d.lpmData = s_q.urow[za[PA-1:0]];
                `NVS_CMD_FAC_RD: s_d.lpmData = facByte(za[PA-1:0]);
                default:         s_d.lpmData = s_q.flash[za];
            endcase
        if (spmOk && c == `NVS_CMD_BUF_LD) begin
            s_d.pbuf[{za[PA-1:1], 1'b0}] = lnk.spmWord[7:0];
            s_d.pbuf[{za[PA-1:1], 1'b1}] = lnk.spmWord[15:8];
        end
        if (spmOk && prot) begin
            s_d.opCmd = c;
            s_d.opAddr = za;
            s_d.cnt = `NVS_OP_CYCLES;
            s_d.st = DST_RUN;
            case (c)
                // generic pages halt only in boot
                `NVS_CMD_PG_ER, `NVS_CMD_PG_WR, `NVS_CMD_PG_EW:
                    s_d.halt = (za >= BOOT_START);
                `NVS_CMD_MPG_ER, `NVS_CMD_MPG_WR, `NVS_CMD_MPG_EW: ;
                `NVS_CMD_MAIN_ER, `NVS_CMD_BPG_ER, `NVS_CMD_BPG_WR,
                `NVS_CMD_BPG_EW, `NVS_CMD_USR_ER, `NVS_CMD_USR_WR:
                    s_d.halt = 1'b1;
                default: s_d.st = DST_IDLE;
            endcase
        end
        if (exOk) begin
            s_d.opCmd = c;
            s_d.crc = `NVS_CRC_INIT;
            s_d.st = DST_CRC;
            case (c)
                `NVS_CMD_BUF_ER, `NVS_CMD_EE_ER, `NVS_CMD_EE_LD,
                `NVS_CMD_EE_RD: begin
                    s_d.st = DST_RUN;
                    s_d.cnt = `NVS_OP_CYCLES;
                end
                `NVS_CMD_MAIN_CRC: begin
                    s_d.opAddr = '0;
                    s_d.crcEnd = BOOT_START - FA'(1);
                end
                `NVS_CMD_BOOT_CRC: begin
                    s_d.opAddr = BOOT_START;
                    s_d.crcEnd = FA'(FLASH_BYTES - 1);
                end
                `NVS_CMD_RNG_CRC: begin
                    s_d.opAddr = s_q.data[FA-1:0];
                    s_d.crcEnd = s_q.addr[FA-1:0];
                    if (!bootLockFree) s_d.st = DST_IDLE;
                end
                default: s_d.st = DST_IDLE;
            endcase
            s_d.halt = (s_d.st == DST_CRC);
        end
        // Sequencer
        case (s_q.st)
            DST_RUN: begin
                s_d.cnt = s_q.cnt - 8'h01;
                if (s_q.cnt == 8'h01) begin
                    s_d.st = DST_IDLE;
                    for (int i = 0; i < FLASH_BYTES; i++) begin
                        if (pageOf(FA'(i)) == pageOf(s_q.opAddr)) begin
                            case (s_q.opCmd)
                                `NVS_CMD_PG_ER, `NVS_CMD_MPG_ER,
                                `NVS_CMD_BPG_ER:
                                    s_d.flash[i] = `NVS_ERASED;
                                `NVS_CMD_PG_WR, `NVS_CMD_MPG_WR,
                                `NVS_CMD_BPG_WR:
                                    s_d.flash[i] = s_q.flash[i]
                                        & s_q.pbuf[i % PAGE_BYTES];
                                `NVS_CMD_PG_EW, `NVS_CMD_MPG_EW,
                                `NVS_CMD_BPG_EW:
                                    s_d.flash[i] = s_q.pbuf[i % PAGE_BYTES];
                                default: ;
                            endcase
                        end
                        if (s_q.opCmd == `NVS_CMD_MAIN_ER
                            && FA'(i) < BOOT_START)
                            s_d.flash[i] = `NVS_ERASED;
                    end
                    case (s_q.opCmd)
                        `NVS_CMD_BUF_ER: s_d.pbuf = '1;
                        `NVS_CMD_USR_ER: s_d.urow = '1;
                        `NVS_CMD_USR_WR: s_d.urow = s_q.urow & s_q.pbuf;
                        // EEPROM read to data byte zero
                        `NVS_CMD_EE_RD:
                            s_d.data[7:0] = s_q.ee[s_q.addr[EA-1:0]];
                        `NVS_CMD_EE_LD: s_d.eeTag[s_q.addr[EA-1:EP]] = 1'b1;
                        `NVS_CMD_EE_ER: begin
                            for (int i = 0; i < EE_BYTES; i++)
                                if (s_q.eeTag[i / EE_PAGE])
                                    s_d.ee[i] = `NVS_ERASED;
                            s_d.eeTag = '0;
                        end
                        default: ;
                    endcase
                end
            end
            DST_CRC: begin
                s_d.crc = crcNext;
                s_d.opAddr = s_q.opAddr + FA'(1);
                if (s_q.opAddr == s_q.crcEnd) begin
                    s_d.st = DST_IDLE;
                    s_d.data = {8'h00, crcNext};
                end
            end
            default: ;
        endcase
        // Busy follows the sequencer; halt never outlives busy
        s_d.busy = (s_d.st != DST_IDLE);
        if (!s_d.busy) s_d.halt = 1'b0;
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.flash <= '1;
            s_q.pbuf <= '1;
            s_q.urow <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the register
    assign lnk.lpmValid = s_q.lpmValid;
    assign lnk.lpmData = s_q.lpmData;
    assign lnk.busy = s_q.busy;
    assign lnk.cpuHalt = s_q.halt;
    assign lnk.dataRd = s_q.data;
    assign extValid = s_q.extValid;
    assign extData = s_q.extData;
endmodule : nvs_device
`default_nettype wire

// ==== nvs_host.sv ====
// CPU end: turns one user operation into the register and trigger sequence.
// Assumes the controller end on nvs_if.host and the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "nvs_cfg.svh"
module nvs_host import nvs_pkg::*; (
    input  wire logic        clk,
    input  wire logic        srst,
    nvs_if.host              lnk,
    input  wire logic        uReq,
    input  wire nvs_op_t     uOp,
    input  wire logic [6:0]  uCmd,
    input  wire logic [23:0] uAddr,
    input  wire logic [23:0] uData,
    output logic             uReady,
    output logic             uDone,
    output logic [23:0]      uResult,
    output logic             irqOff
);
    typedef struct packed {
        nvs_hstate_t st;
        nvs_op_t     op;
        logic [6:0]  cmd;
        logic [23:0] addr;
        logic [23:0] data;
        logic        cmdWr;
        logic        addrWr;
        logic        dataWr;
        logic        ccpKey;
        logic        execReq;
        logic        spmReq;
        logic        lpmReq;
        logic        ready;
        logic        done;
        logic [23:0] result;
        logic        irqOff;
    } nvs_host_t;

    nvs_host_t s_q;
    nvs_host_t s_d;

    // ==========================================================
    // Sequence: command, address, unlock, trigger, wait
    always_comb begin
        s_d = s_q;
        s_d.cmdWr = 1'b0;
        s_d.addrWr = 1'b0;
        s_d.dataWr = 1'b0;
        s_d.ccpKey = 1'b0;
        s_d.execReq = 1'b0;
        s_d.spmReq = 1'b0;
        s_d.lpmReq = 1'b0;
        s_d.done = 1'b0;
        case (s_q.st)
            HST_IDLE: begin
                if (uReq && s_q.ready && !lnk.cpuHalt) begin
                    s_d.op = uOp;
                    s_d.cmd = uCmd;
                    s_d.addr = uAddr;
                    s_d.data = uData;
                    s_d.ready = 1'b0;
                    s_d.st = HST_CMD;
                    s_d.irqOff = (uOp == OP_LOAD)
                        && (uCmd == `NVS_CMD_USR_RD
                            || uCmd == `NVS_CMD_FAC_RD);
                end
            end
            HST_CMD: begin
                s_d.cmdWr = 1'b1;
                s_d.st = HST_ADDR;
            end
            HST_ADDR: begin
                s_d.addrWr = 1'b1;
                s_d.dataWr = 1'b1;
                s_d.st = HST_CCP;
            end
            HST_CCP: begin
                s_d.ccpKey = (s_q.op != OP_LOAD);
                s_d.st = HST_GO;
            end
            HST_GO: begin
                s_d.lpmReq = (s_q.op == OP_LOAD);
                s_d.spmReq = (s_q.op == OP_STORE);
                s_d.execReq = (s_q.op == OP_EXEC);
                s_d.st = HST_WAIT;
            end
            HST_WAIT: begin
                if (s_q.lpmReq || s_q.spmReq || s_q.execReq) begin
                    s_d.st = HST_WAIT;
                end else if (!lnk.busy) begin
                    s_d.result = (s_q.op == OP_LOAD)
                        ? {16'h0000, lnk.lpmData} : lnk.dataRd;
                    s_d.done = 1'b1;
                    s_d.ready = 1'b1;
                    s_d.irqOff = 1'b0;
                    s_d.st = HST_IDLE;
                end
            end
            default: s_d.st = HST_IDLE;
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.st <= HST_IDLE;
            s_q.op <= OP_LOAD;
            s_q.ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign lnk.cmdVal = s_q.cmd;
    assign lnk.cmdWr = s_q.cmdWr;
    assign lnk.addrVal = s_q.addr;
    assign lnk.addrWr = s_q.addrWr;
    assign lnk.dataVal = s_q.data;
    assign lnk.dataWr = s_q.dataWr;
    assign lnk.ccpKey = s_q.ccpKey;
    assign lnk.execReq = s_q.execReq;
    assign lnk.spmReq = s_q.spmReq;
    assign lnk.lpmReq = s_q.lpmReq;
    assign lnk.ptrAddr = s_q.addr;
    assign lnk.spmWord = s_q.data[15:0];
    assign uReady = s_q.ready;
    assign uDone = s_q.done;
    assign uResult = s_q.result;
    assign irqOff = s_q.irqOff;
endmodule : nvs_host
`default_nettype wire

// ==== nvs_if.sv ====
// Link between the CPU end and the memory controller end.
// Assumes one shared clock; every signal is a level sampled on clk.
`timescale 1ns/1ps
`default_nettype none
interface nvs_if;
    logic [6:0]  cmdVal;
    logic        cmdWr;
    logic [23:0] addrVal;
    logic        addrWr;
    logic [23:0] dataVal;
    logic        dataWr;
    logic        ccpKey;
    logic        execReq;
    logic        spmReq;
    logic        lpmReq;
    logic [23:0] ptrAddr;
    logic [15:0] spmWord;
    logic        lpmValid;
    logic [7:0]  lpmData;
    logic        busy;
    logic        cpuHalt;
    logic [23:0] dataRd;
    modport host (output cmdVal, cmdWr, addrVal, addrWr, dataVal, dataWr,
        ccpKey, execReq, spmReq, lpmReq, ptrAddr, spmWord,
        input lpmValid, lpmData, busy, cpuHalt, dataRd);
    modport dev (input cmdVal, cmdWr, addrVal, addrWr, dataVal, dataWr,
        ccpKey, execReq, spmReq, lpmReq, ptrAddr, spmWord,
        output lpmValid, lpmData, busy, cpuHalt, dataRd);
endinterface : nvs_if
`default_nettype wire

// ==== nvs_monitor.sv ====
// Checker for the link between the CPU end and the controller end.
// Assumes the bench connects the interface signals to its ports.
`timescale 1ns/1ps
`default_nettype none
module nvs_monitor #(
    parameter int FLASH_BYTES = 64,
    parameter int BOOT_BYTES  = 16
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [6:0]  cmdVal,
    input wire logic        cmdWr,
    input wire logic        execReq,
    input wire logic        spmReq,
    input wire logic        lpmReq,
    input wire logic [23:0] ptrAddr,
    input wire logic        lpmValid,
    input wire logic        busy,
    input wire logic        cpuHalt
);
    // ==========
    // Helper state
    logic [6:0] cmdReg_q;
    logic [6:0] lastCmd_q;
    logic       bootPg_q;
    logic [7:0] busyCnt_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Command mirror, accepted trigger, busy length
    always_ff @(posedge clk) begin
        if (srst) begin
            cmdReg_q  <= 7'h00;
            lastCmd_q <= 7'h00;
            bootPg_q  <= 1'b0;
            busyCnt_q <= 8'h00;
        end else begin
            if (cmdWr) cmdReg_q <= cmdVal;
            if ((spmReq || execReq) && !busy) begin
                lastCmd_q <= cmdReg_q;
                bootPg_q  <= ptrAddr >= 24'(FLASH_BYTES - BOOT_BYTES);
            end
            busyCnt_q <= busy ? busyCnt_q + 8'h01 : 8'h00;
        end
    end
    // ==========
    // Link properties
    a_load_answer: assert property (lpmReq |=> lpmValid)
        else $error("load not answered");
    a_load_cause: assert property (lpmValid |-> $past(lpmReq))
        else $error("load answer without trigger");
    a_buffer_quiet: assert property (
        spmReq && !busy && cmdReg_q == 7'h23 |=> !busy)
        else $error("buffer load set busy");
    a_rise_cause: assert property (
        $rose(busy) |-> $past(spmReq || execReq))
        else $error("busy rose without trigger");
    a_main_runs: assert property (
        $rose(busy) && lastCmd_q inside {7'h22, 7'h24, 7'h25} |-> !cpuHalt)
        else $error("main page op halted cpu");
    a_halt_kept: assert property ($rose(busy) && lastCmd_q inside
        {7'h20, 7'h2a, 7'h2c, 7'h2d, 7'h18, 7'h1a, 7'h38, 7'h39, 7'h3a}
        |-> cpuHalt)
        else $error("cpu not halted");
    a_generic_halt: assert property ($rose(busy) &&
        lastCmd_q inside {7'h2b, 7'h2e, 7'h2f} |-> cpuHalt == bootPg_q)
        else $error("generic page halt wrong");
    a_op_length: assert property ($fell(busy) &&
        !(lastCmd_q inside {7'h38, 7'h39, 7'h3a}) |-> busyCnt_q == 8'h10)
        else $error("busy length wrong");
    // Main scenarios
    c_halted: cover property ($rose(cpuHalt));
    c_crc_done: cover property ($fell(busy) && lastCmd_q == 7'h3a);
    c_load: cover property (lpmValid);
endmodule : nvs_monitor
`default_nettype wire

// ==== nvs_pkg.sv ====
// Types shared by both ends of the flash command sequencer.
// Assumes nvs_cfg.svh is on the include path.
package nvs_pkg;
    // Device sequencer states
    typedef enum logic [1:0] {DST_IDLE, DST_RUN, DST_CRC} nvs_dstate_t;
    // Host sequencer states
    typedef enum logic [2:0] {
        HST_IDLE, HST_CMD, HST_ADDR, HST_CCP, HST_GO, HST_WAIT
    } nvs_hstate_t;
    // Host operations
    typedef enum logic [1:0] {OP_LOAD, OP_STORE, OP_EXEC} nvs_op_t;
endpackage : nvs_pkg

// ==== nvs_tb.sv ====
// Bench joining both ends; drives the user side and the external port.
// Assumes the design files and nvs_monitor.sv are compiled first.
`timescale 1ns/1ps
`default_nettype none
module nvs_tb import nvs_pkg::*; ;
    // ==========
    // Bench signals
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        uReq = 1'b0;
    logic        lockFree = 1'b1;
    logic        extReq = 1'b0;
    logic [23:0] extAddr = 24'h0;
    nvs_op_t     uOp = OP_LOAD;
    logic [6:0]  uCmd = 7'h00;
    logic [23:0] uAddr = 24'h0;
    logic [23:0] uData = 24'h0;
    logic        uReady, uDone, extValid, irqOff;
    int          irqCnt = 0;
    logic [23:0] uResult;
    logic [7:0]  extData;
    int          errTotal = 0;
    int          cmpCount = 0;
    int          lat;
    logic [6:0]  codes [9] = '{7'h2f, 7'h2f, 7'h22, 7'h24, 7'h25, 7'h2a,
                               7'h2d, 7'h18, 7'h20};
    nvs_if nvs_if_i ();
    nvs_host nvs_host_i (.clk(clk), .srst(srst), .lnk(nvs_if_i.host),
        .uReq(uReq), .uOp(uOp), .uCmd(uCmd), .uAddr(uAddr), .uData(uData),
        .uReady(uReady), .uDone(uDone), .uResult(uResult), .irqOff(irqOff));
    // Count cycles with interrupts masked by the CPU end
    always @(posedge clk) begin
        if (irqOff === 1'b1) irqCnt <= irqCnt + 1;
    end
    nvs_device nvs_device_i (.clk(clk), .srst(srst), .lnk(nvs_if_i.dev),
        .bootLockFree(lockFree), .extReq(extReq), .extAddr(extAddr),
        .extValid(extValid), .extData(extData));
    nvs_monitor #(.FLASH_BYTES(64), .BOOT_BYTES(16)) nvs_monitor_i (
        .clk(clk), .srst(srst), .cmdVal(nvs_if_i.cmdVal),
        .cmdWr(nvs_if_i.cmdWr), .execReq(nvs_if_i.execReq),
        .spmReq(nvs_if_i.spmReq), .lpmReq(nvs_if_i.lpmReq),
        .ptrAddr(nvs_if_i.ptrAddr), .lpmValid(nvs_if_i.lpmValid),
        .busy(nvs_if_i.busy), .cpuHalt(nvs_if_i.cpuHalt));
    // ==========
    // Tasks
    task automatic chk(input string nm, input logic [23:0] e, g);
        cmpCount++;
        if (g !== e) begin
            errTotal++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic chkLat(input int e);
        cmpCount++;
        if (lat != e) begin
            errTotal++;
            $display("wrong value latency exp %0d got %0d", e, lat);
        end
    endtask : chkLat
    // One user operation; lat counts cycles from request to done
    task automatic op(input nvs_op_t o, input logic [6:0] c,
                      input logic [23:0] a, input logic [23:0] d);
        int n;
        n = 0;
        while (!(uReady === 1'b1 && nvs_if_i.cpuHalt === 1'b0)
               && n < 300) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        uOp <= o;
        uCmd <= c;
        uAddr <= a;
        uData <= d;
        uReq <= 1'b1;
        @(posedge clk);
        uReq <= 1'b0;
        lat = 0;
        @(negedge clk);
        while (uDone !== 1'b1 && lat < 300) begin
            @(negedge clk);
            lat++;
        end
    endtask : op
    task automatic run(input nvs_op_t o, input logic [6:0] c,
                       input logic [23:0] a, d, input int e);
        op(o, c, a, d);
        chkLat(e);
    endtask : run
    task automatic rd(input logic [6:0] c, input logic [23:0] a,
                      input logic [7:0] e);
        int n0;
        n0 = irqCnt;
        run(OP_LOAD, c, a, 24'h0, 6);
        chk("load", {16'h0, e}, {16'h0, uResult[7:0]});
        chk("irq", 24'(c inside {7'h01, 7'h02}), 24'(irqCnt != n0));
    endtask : rd
    task automatic ext(input logic [23:0] a, input logic [7:0] e);
        int n;
        n = 0;
        @(posedge clk);
        extReq <= 1'b1;
        extAddr <= a;
        @(posedge clk);
        extReq <= 1'b0;
        @(negedge clk);
        while (extValid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        chk("ext", {16'h0, e}, {16'h0, extData});
    endtask : ext
    function automatic logic [15:0] crcFf(input int n);
        logic [15:0] c;
        c = 16'hffff;
        repeat (8 * n) c = {c[14:0], 1'b0} ^ (c[15] ? 16'h0000 : 16'h1021);
        return c;
    endfunction : crcFf
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    // ==========
    // Clock, watchdog, main sequence
    initial forever #20 clk = ~clk;
    initial begin
        repeat (8000) @(posedge clk);
        errTotal++;
        wrap_up;
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        rd(7'h00, 24'h5, 8'hff);
        run(OP_STORE, 7'h23, 24'h0, 24'h1234, 6);
        run(OP_STORE, 7'h2e, 24'h0, 24'h0, 22);
        rd(7'h00, 24'h0, 8'h34);
        rd(7'h00, 24'h1, 8'h12);
        run(OP_STORE, 7'h2b, 24'h0, 24'h0, 22);
        rd(7'h00, 24'h1, 8'hff);
        run(OP_EXEC, 7'h26, 24'h0, 24'h0, 22);
        run(OP_STORE, 7'h23, 24'h30, 24'h00aa, 6);
        run(OP_STORE, 7'h2c, 24'h30, 24'h0, 22);
        rd(7'h00, 24'h30, 8'haa);
        run(OP_EXEC, 7'h26, 24'h0, 24'h0, 22);
        run(OP_STORE, 7'h23, 24'h0, 24'h00a5, 6);
        run(OP_STORE, 7'h1a, 24'h0, 24'h0, 22);
        rd(7'h01, 24'h0, 8'ha5);
        ext(24'h002000, 8'ha5);
        rd(7'h02, 24'h3, 8'h53);
        rd(7'h7f, 24'h30, 8'haa);
        op(OP_EXEC, 7'h33, 24'h4, 24'h0);
        run(OP_EXEC, 7'h30, 24'h0, 24'h0, 22);
        op(OP_EXEC, 7'h06, 24'h5, 24'h0);
        chk("eeprom", 24'hff, {16'h0, uResult[7:0]});
        op(OP_EXEC, 7'h06, 24'h1, 24'h0);
        chk("eeprom", 24'h00, {16'h0, uResult[7:0]});
        run(OP_EXEC, 7'h3a, 24'hb, 24'h8, 10);
        chk("range crc", {8'h0, crcFf(4)}, uResult);
        @(posedge clk);
        lockFree <= 1'b0;
        run(OP_EXEC, 7'h3a, 24'hb, 24'h8, 6);
        @(posedge clk);
        lockFree <= 1'b1;
        run(OP_EXEC, 7'h38, 24'h0, 24'h0, 54);
        run(OP_EXEC, 7'h39, 24'h0, 24'h0, 22);
        for (int i = 0; i < 9; i++) begin
            run(OP_STORE, codes[i], (i == 1 || i == 5 || i == 6) ?
                24'h38 : 24'h8, 24'h0, 22);
        end
        rd(7'h00, 24'h8, 8'hff);
        ext(24'h000030, 8'haa);
        ext(24'h003003, 8'h53);
        ext(24'h001005, 8'hff);
        wrap_up;
    end
endmodule : nvs_tb
`default_nettype wire
